// ===== touch_adc_pkg.sv
/*
  Constants and types shared by the touch-screen converter control logic.
  Assumes nothing of its surroundings.
*/
package touch_adc_pkg;

  // ==========================================================================
  // Command byte layout
  localparam int          CMD_W       = 8;
  localparam int          REF_POS     = 2;
  localparam int          RES_POS     = 3;
  localparam logic [3:0]  CMD_FULL    = 4'h8;
  localparam logic [3:0]  ACQ_BIT     = 4'h5;
  localparam logic [3:0]  OVERLAP_MIN = 4'h6;

  // ==========================================================================
  // Channel address and power select codes
  localparam logic [2:0]  ADDR_Y_POS  = 3'h1;
  localparam logic [2:0]  ADDR_X_POS  = 3'h5;
  localparam logic [2:0]  ADDR_AUX_A  = 3'h2;
  localparam logic [2:0]  ADDR_AUX_B  = 3'h6;
  localparam logic [1:0]  PWR_AUTO    = 2'h0;
  localparam logic [1:0]  PWR_RSVD    = 2'h2;
  localparam logic [1:0]  PWR_RESET   = 2'h0;

  // ==========================================================================
  // Conversion lengths
  localparam int          RES_FULL    = 12;
  localparam logic [3:0]  DEC_FULL    = 4'hc;
  localparam logic [3:0]  DEC_SHORT   = 4'h8;

  typedef enum logic [1:0] {IN_X_PLUS, IN_Y_PLUS, IN_AUX_A, IN_AUX_B} adc_in_t;
  typedef enum logic {CMD_HUNT, CMD_SHIFT} cmd_state_t;

endpackage : touch_adc_pkg

// ===== serial_edges.sv
/*
  Edge detector for the serial clock and chip select.
  Assumes both inputs are synchronous to clk.
*/
`timescale 1ns/1ps
module serial_edges (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic serial_clock,
  input  wire logic chip_select_n,
  output logic      sclk_rise,
  output logic      sclk_fall,
  output logic      cs_fall
);
  logic sclk_q;
  logic cs_n_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      sclk_q <= serial_clock;
      cs_n_q <= chip_select_n;
    end
  end

  assign sclk_rise = serial_clock && !sclk_q;
  assign sclk_fall = !serial_clock && sclk_q;
  assign cs_fall   = !chip_select_n && cs_n_q;
endmodule : serial_edges

// ===== sar_engine.sv
/*
  Successive-approximation register: trial code and decision count.
  Assumes start and step are one-cycle pulses and comp_high is the
  comparator answer for the current trial code.
*/
`timescale 1ns/1ps
module sar_engine
  import touch_adc_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                start,
  input  wire logic                step,
  input  wire logic                abort,
  input  wire logic                short_mode,
  input  wire logic                comp_high,
  output logic [RES_FULL-1:0]      code_q,
  output logic                     active_q,
  output logic [3:0]               dec_cnt_q,
  output logic                     done_q
);
  logic [3:0] idx_q;
  logic       last;

  assign last = (dec_cnt_q + 4'h1) == (short_mode ? DEC_SHORT : DEC_FULL);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      active_q  <= 1'b0;
      dec_cnt_q <= 4'h0;
      idx_q     <= 4'h0;
      done_q    <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (abort) begin
        active_q <= 1'b0;
      end else if (start) begin
        active_q  <= 1'b1;
        dec_cnt_q <= 4'h0;
        idx_q     <= 4'(RES_FULL - 1);
      end else if (step && active_q) begin
        dec_cnt_q <= dec_cnt_q + 4'h1;
        idx_q     <= idx_q - 4'h1;
        if (last) begin
          active_q <= 1'b0;
          done_q   <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Per-bit trial and decision
  for (genvar i = 0; i < RES_FULL; i++) begin : g_bit
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        code_q[i] <= 1'b0;
      end else if (start && !abort) begin
        code_q[i] <= (i == RES_FULL - 1);
      end else if (step && active_q && !abort) begin
        if (idx_q == 4'(i)) begin
          code_q[i] <= comp_high;
        end else if (idx_q == 4'(i + 1) && !last) begin
          code_q[i] <= 1'b1;
        end
      end
    end
  end
endmodule : sar_engine

// ===== touch_adc_ctrl.sv
/*
  Serial command capture and conversion control of a four-wire touch ADC.
  Assumes serial_clock, chip_select_n and serial_in are synchronous to clk
  and far slower than it; the analog comparator answers within one clk.
*/
//
// Contract
// - Single-ended address 001/101 drive Y/X panel; 010/110 pick aux inputs.
// - Differential 001/101 reference from driven layer, sample other layer.
// - Reference-mode bit 1 means single-ended, 0 means differential.
// - Single-ended converts against fixed reference; drivers off after acquisition.
// - Differential keeps drivers on through acquisition and conversion.
// - With alert enabled, touch alert pulled low while panel touched.
// - Alert valid again after last result bit or chip select high.
// - Chip select high disables interface; data and busy outputs float.
// - Serial input captured on each rising serial clock while selected.
// - Leading zeros ignored; first 1 is the start bit.
// - Busy period, twelve result bits, then three zero bits fill two bytes.
// - Result straight binary, MSB first, changing on falling edges.
// - Busy high one period after command; twelve decisions follow.
// - Conversion begins on falling edge after eighth command bit.
// - During conversion a 1 after bit 6 starts next command.
// - An accepted conversion runs to completion unless chip select goes high.
// - Conversions every 15 clocks; free-running host first sends 16 zeros.
// - Resolution bit high gives 8-bit conversion, four clocks shorter.
// - Command byte: start, address, resolution, reference mode, power select.
// - Power 00 on only converting with alert; 01/11 stay on until chip select goes high.
// - Chip select rising powers down and aborts conversion.
// - After reset the data output shifts zeros until a conversion.
`timescale 1ns/1ps
module touch_adc_ctrl (
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic                        serial_clock,
  input  wire logic                        chip_select_n,
  input  wire logic                        serial_in,
  input  wire logic                        comp_high,
  input  wire logic                        pen_touched,
  input  wire logic                        touch_alert_n_in,
  output logic                             touch_alert_n_out,
  output logic                             touch_alert_n_oe,
  output logic                             serial_out,
  output logic                             serial_out_oe,
  output logic                             busy,
  output logic                             busy_oe,
  output logic                             x_drv_on,
  output logic                             y_drv_on,
  output touch_adc_pkg::adc_in_t           adc_in_sel,
  output logic                             ref_diff,
  output logic                             acquiring,
  output logic                             adc_power,
  output logic [touch_adc_pkg::RES_FULL-1:0] dac_code
);
  import touch_adc_pkg::*;

  // ==========================================================================
  // Edges and conversion engine
  logic             sclk_rise;
  logic             sclk_fall;
  logic             cs_fall;
  logic             sar_active;
  logic             sar_done;
  logic [3:0]       dec_cnt;
  logic [CMD_W-1:0] shreg_q;
  logic [3:0]       cmd_cnt_q;
  cmd_state_t       cmd_state_q;
  logic             short_q;
  logic [1:0]       pwr_cfg_q;
  logic             mask_q;
  logic             alert_out_q;
  logic             dout_q;
  logic             dout_oe_q;
  logic             busy_q;
  logic             busy_oe_q;
  logic             xdrv_q;
  logic             ydrv_q;
  adc_in_t          sel_q;
  logic             diff_q;
  logic             acq_q;
  logic             pwr_q;
  logic             hunt_ok;
  logic             cmd_full;
  logic             conv_start;
  logic             acq_edge;

  serial_edges u_edges (
    .clk           (clk),
    .resetn        (resetn),
    .serial_clock  (serial_clock),
    .chip_select_n (chip_select_n),
    .sclk_rise     (sclk_rise),
    .sclk_fall     (sclk_fall),
    .cs_fall       (cs_fall)
  );

  sar_engine u_sar (
    .clk        (clk),
    .resetn     (resetn),
    .start      (conv_start),
    .step       (sclk_fall),
    .abort      (chip_select_n),
    .short_mode (short_q),
    .comp_high  (comp_high),
    .code_q     (dac_code),
    .active_q   (sar_active),
    .dec_cnt_q  (dec_cnt),
    .done_q     (sar_done)
  );

  assign hunt_ok    = !sar_active || (dec_cnt > OVERLAP_MIN);
  assign cmd_full   = (cmd_state_q == CMD_SHIFT) && (cmd_cnt_q == CMD_FULL);
  assign conv_start = sclk_fall && cmd_full && !chip_select_n;
  assign acq_edge   = sclk_fall && (cmd_state_q == CMD_SHIFT) && (cmd_cnt_q == ACQ_BIT);

  // ==========================================================================
  // Command shift register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_state_q <= CMD_HUNT;
      cmd_cnt_q   <= 4'h0;
      shreg_q     <= '0;
    end else if (chip_select_n) begin
      cmd_state_q <= CMD_HUNT;
      cmd_cnt_q   <= 4'h0;
    end else if (sclk_rise) begin
      case (cmd_state_q)
        CMD_HUNT: begin
          if (serial_in && hunt_ok) begin
            shreg_q     <= {shreg_q[CMD_W-2:0], serial_in};
            cmd_cnt_q   <= 4'h1;
            cmd_state_q <= CMD_SHIFT;
          end
        end
        CMD_SHIFT: begin
          if (cmd_cnt_q != CMD_FULL) begin
            shreg_q   <= {shreg_q[CMD_W-2:0], serial_in};
            cmd_cnt_q <= cmd_cnt_q + 4'h1;
          end
        end
        default: cmd_state_q <= CMD_HUNT;
      endcase
    end else if (sclk_fall && cmd_full) begin
      cmd_state_q <= CMD_HUNT;
      cmd_cnt_q   <= 4'h0;
    end
  end

  // ==========================================================================
  // Panel drivers, reference, power
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      xdrv_q    <= 1'b0;
      ydrv_q    <= 1'b0;
      sel_q     <= IN_X_PLUS;
      diff_q    <= 1'b0;
      acq_q     <= 1'b0;
      pwr_q     <= 1'b0;
      short_q   <= 1'b0;
      pwr_cfg_q <= PWR_RESET;
    end else if (chip_select_n) begin
      xdrv_q <= 1'b0;
      ydrv_q <= 1'b0;
      acq_q  <= 1'b0;
      pwr_q  <= 1'b0;
    end else if (acq_edge) begin
      acq_q  <= 1'b1;
      pwr_q  <= 1'b1;
      xdrv_q <= (shreg_q[3:1] == ADDR_X_POS);
      ydrv_q <= (shreg_q[3:1] == ADDR_Y_POS);
      case (shreg_q[3:1])
        ADDR_X_POS: sel_q <= IN_Y_PLUS;
        ADDR_AUX_A: sel_q <= IN_AUX_A;
        ADDR_AUX_B: sel_q <= IN_AUX_B;
        default:    sel_q <= IN_X_PLUS;
      endcase
    end else if (conv_start) begin
      acq_q     <= 1'b0;
      diff_q    <= !shreg_q[REF_POS];
      short_q   <= shreg_q[RES_POS];
      pwr_cfg_q <= shreg_q[1:0];
      if (shreg_q[REF_POS]) begin
        xdrv_q <= 1'b0;
        ydrv_q <= 1'b0;
      end
    end else if (sar_done && !acq_q) begin
      xdrv_q <= 1'b0;
      ydrv_q <= 1'b0;
      pwr_q  <= (pwr_cfg_q != PWR_AUTO) && (pwr_cfg_q != PWR_RSVD);
    end
  end

  // ==========================================================================
  // Serial output and busy
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dout_q    <= 1'b0;
      busy_q    <= 1'b0;
      dout_oe_q <= 1'b0;
      busy_oe_q <= 1'b0;
    end else begin
      dout_oe_q <= !chip_select_n;
      busy_oe_q <= !chip_select_n;
      if (chip_select_n) begin
        busy_q <= 1'b0;
        dout_q <= 1'b0;
      end else if (sclk_fall) begin
        busy_q <= cmd_full;
        dout_q <= sar_active ? comp_high : 1'b0;
      end
    end
  end

  // ==========================================================================
  // Touch alert
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mask_q           <= 1'b0;
      alert_out_q      <= 1'b0;
      touch_alert_n_oe <= 1'b0;
    end else begin
      if (chip_select_n || sar_done) begin
        mask_q <= 1'b0;
      end else if (cs_fall) begin
        mask_q <= 1'b1;
      end
      touch_alert_n_oe <= (pwr_cfg_q == PWR_AUTO) && pen_touched && !mask_q;
    end
  end

  assign touch_alert_n_out = alert_out_q;
  assign serial_out        = dout_q;
  assign serial_out_oe     = dout_oe_q;
  assign busy              = busy_q;
  assign busy_oe           = busy_oe_q;
  assign x_drv_on          = xdrv_q;
  assign y_drv_on          = ydrv_q;
  assign adc_in_sel        = sel_q;
  assign ref_diff          = diff_q;
  assign acquiring         = acq_q;
  assign adc_power         = pwr_q;

  // ==========================================================================
  // Checks
  property p_busy_one;
    @(posedge clk) disable iff (!resetn)
      (busy_q && !sclk_fall && !chip_select_n) |=> busy_q;
  endproperty
  a_busy_one: assert property (p_busy_one) else $error("busy dropped early");

  property p_busy_clear;
    @(posedge clk) disable iff (!resetn)
      (busy_q && sclk_fall && !cmd_full) |=> !busy_q && sar_active;
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy not one period");

  property p_start_cause;
    @(posedge clk) disable iff (!resetn)
      $rose(busy_q) |-> $past(cmd_cnt_q) == CMD_FULL && $past(sclk_fall);
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("busy without full byte");

  property p_float;
    @(posedge clk) disable iff (!resetn)
      chip_select_n |=> !serial_out_oe && !busy_oe;
  endproperty
  a_float: assert property (p_float) else $error("outputs driven while deselected");

  property p_abort;
    @(posedge clk) disable iff (!resetn)
      $rose(chip_select_n) |=> !sar_active && !adc_power && !x_drv_on && !y_drv_on;
  endproperty
  a_abort: assert property (p_abort) else $error("deselect did not abort");

  property p_se_off;
    @(posedge clk) disable iff (!resetn)
      (conv_start && shreg_q[REF_POS]) |=> !x_drv_on && !y_drv_on && !ref_diff;
  endproperty
  a_se_off: assert property (p_se_off) else $error("drivers on in single-ended");

  property p_diff_hold;
    @(posedge clk) disable iff (!resetn)
      (sar_active && ref_diff && !chip_select_n && !sar_done) |=> $stable(x_drv_on) || sar_done;
  endproperty
  a_diff_hold: assert property (p_diff_hold) else $error("drivers moved in differential");

  property p_addr;
    @(posedge clk) disable iff (!resetn)
      (acq_edge && !chip_select_n && shreg_q[3:1] == ADDR_Y_POS) |=> y_drv_on && !x_drv_on
        && adc_in_sel == IN_X_PLUS;
  endproperty
  a_addr: assert property (p_addr) else $error("Y address decode wrong");

  property p_alert;
    @(posedge clk) disable iff (!resetn)
      (pen_touched && !mask_q && pwr_cfg_q == PWR_AUTO) |=> touch_alert_n_oe;
  endproperty
  a_alert: assert property (p_alert) else $error("touch alert not asserted");

  property p_zero_tail;
    @(posedge clk) disable iff (!resetn)
      (sclk_fall && !sar_active && !chip_select_n) |=> !serial_out;
  endproperty
  a_zero_tail: assert property (p_zero_tail) else $error("nonzero pad bit");

  property p_leading_zero;
    @(posedge clk) disable iff (!resetn)
      (cmd_state_q == CMD_HUNT && sclk_rise && !serial_in) |=> cmd_state_q == CMD_HUNT;
  endproperty
  a_leading_zero: assert property (p_leading_zero) else $error("zero taken as start");
endmodule : touch_adc_ctrl

// ===== host_model.sv
/*
  Host model: mode-0 serial master that selects the converter and shifts frames.
  Assumes clk is the bench clock and HALF clk cycles make half a serial period.
*/
`timescale 1ns/1ps
module host_model #(
  parameter int HALF = 10
) (
  input  wire logic clk,
  output logic      serial_clock,
  output logic      chip_select_n,
  output logic      serial_in
);
  // ==========================================================================
  // Idle: deselected, clock parked low
  initial begin
    serial_clock  = 1'b0;
    chip_select_n = 1'b1;
    serial_in     = 1'b0;
  end

  // ==========================================================================
  // Frame: n bits MSB first; data moves with the falling clock, alert pin unread
  task automatic frame(input logic [63:0] b, input int n, input bit hold);
    int i;
    @(posedge clk);
    chip_select_n <= 1'b0;
    repeat (HALF) @(posedge clk);
    for (i = n - 1; i >= 0; i--) begin
      serial_in <= b[i];
      repeat (HALF) @(posedge clk);
      serial_clock <= 1'b1;
      repeat (HALF) @(posedge clk);
      serial_clock <= 1'b0;
    end
    repeat (HALF) @(posedge clk);
    if (!hold) begin
      chip_select_n <= 1'b1;
    end
  endtask : frame
endmodule : host_model

// ===== touch_adc_serial_control_bench.sv
/*
  Self-checking bench for the touch converter control block.
  Assumes host_model as serial master and a comparator model fed by vin.
*/
`timescale 1ns/1ps
module touch_adc_serial_control_bench;
  import touch_adc_pkg::*;
  localparam int LIMIT = 40000;
  logic                clk         = 1'b0;
  logic                resetn      = 1'b0;
  logic                comp_high   = 1'b0;
  logic                pen_touched = 1'b0;
  logic [11:0]         vin         = 12'h000;
  logic [31:0]         seed        = 32'd85865;
  int                  fail_count  = 0;
  int                  checks_done = 0;
  int                  cyc         = 0;
  int                  ri          = 0;
  logic [64:0]         rx;
  logic [64:0]         bs;
  logic [8:0]          sn [0:64];
  wire                 sclk;
  wire                 csn;
  wire                 sin;
  wire                 alert_pin;
  logic                aout, aoe, so, so_oe, busy, busy_oe, xd, yd, refd, acq, pwr;
  adc_in_t             sel;
  logic [RES_FULL-1:0] code;

  host_model #(.HALF(10)) host (
    .clk(clk), .serial_clock(sclk), .chip_select_n(csn), .serial_in(sin));

  touch_adc_ctrl dut (
    .clk(clk), .resetn(resetn), .serial_clock(sclk), .chip_select_n(csn),
    .serial_in(sin), .comp_high(comp_high), .pen_touched(pen_touched),
    .touch_alert_n_in(alert_pin), .touch_alert_n_out(aout), .touch_alert_n_oe(aoe),
    .serial_out(so), .serial_out_oe(so_oe), .busy(busy), .busy_oe(busy_oe),
    .x_drv_on(xd), .y_drv_on(yd), .adc_in_sel(sel), .ref_diff(refd),
    .acquiring(acq), .adc_power(pwr), .dac_code(code));

  // Open-drain pin with pull-up
  assign alert_pin = aoe ? aout : 1'b1;

  always #20 clk = ~clk;

  // ==========================================================================
  // Comparator model and hang limit
  always @(posedge clk) begin
    comp_high <= (vin >= code);
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fail_count++;
      finish_test();
    end
  end

  // Host-side view at each rising serial clock
  always @(posedge sclk) begin
    ri = ri + 1;
    rx[ri] = so;
    bs[ri] = busy;
    sn[ri] = {so_oe, acq, xd, yd, sel, refd, pwr, aoe};
  end

  // ==========================================================================
  // Expectations
  function automatic logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : rnd

  function automatic logic [64:0] exp_res(input logic [11:0] v, input int st, input bit short);
    logic [64:0] e;
    int i;
    e = '0;
    for (i = 0; i < (short ? 8 : 12); i++) begin
      e[st + 10 + i] = v[11 - i];
    end
    return e;
  endfunction : exp_res

  function automatic logic [3:0] cfg(input logic [2:0] a);
    case (a)
      ADDR_Y_POS: return {2'b01, IN_X_PLUS};
      ADDR_X_POS: return {2'b10, IN_Y_PLUS};
      ADDR_AUX_A: return {2'b00, IN_AUX_A};
      ADDR_AUX_B: return {2'b00, IN_AUX_B};
      default:    return {2'b00, IN_X_PLUS};
    endcase
  endfunction : cfg

  task automatic check(input string name, input logic [64:0] e, input logic [64:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask : check

  task automatic draw;
    repeat (13) seed = rnd(seed);
  endtask : draw

  task automatic idle_check(input bit al);
    repeat (4) @(posedge clk);
    check("idle", 65'({1'b0, 1'b0, 1'b0, al, 1'b0}),
          65'({so_oe, busy_oe, pwr, aoe, aout}));
  endtask : idle_check

  // One full 24-clock conversion with optional leading zeros
  task automatic do_frame(input logic [7:0] cmd, input int lead);
    logic [3:0] c;
    bit         se;
    c = cfg(cmd[6:4]);
    se = cmd[REF_POS];
    ri = 0;
    rx = '0;
    bs = '0;
    host.frame(64'({cmd, 16'h0000}), lead + 24, 1'b0);
    check("result", exp_res(vin, lead, cmd[RES_POS]), rx);
    check("busy", 65'(1) << (lead + 9), bs);
    check("acquire", 65'({2'b11, c}), 65'(sn[lead + 8][8:3]));
    check("convert", 65'({1'b0, se ? 2'b00 : c[3:2], c[1:0], ~se, 2'b10}),
          65'(sn[lead + 12][7:0]));
    check("after", 65'({cmd[0], cmd[1:0] == PWR_AUTO && pen_touched}),
          65'(sn[lead + 24][1:0]));
    if (cmd[1:0] == PWR_AUTO) begin
      idle_check(pen_touched);
    end else begin
      check("alert_off", 65'(0), 65'(aoe));
      idle_check(1'b0);
    end
  endtask : do_frame

  // ==========================================================================
  // Main sequence
  initial begin
    int i;
    pen_touched <= 1'b1;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    check("reset", 65'(4'b1000), 65'({aoe, aout, so_oe, busy_oe}));
    for (i = 0; i < 10; i++) begin
      draw();
      @(posedge clk);
      vin <= (i == 0) ? 12'hfff : (i == 1) ? 12'h000 : seed[27:16];
      pen_touched <= seed[12];
      do_frame({1'b1, seed[6:4], seed[3], seed[2], 2'(i)}, int'(seed[9:8]));
    end
    ri = 0;
    host.frame(64'({8'h95, 6'h00}), 14, 1'b0);
    repeat (4) @(posedge clk);
    check("abort", 65'(0), 65'({so_oe, busy_oe, pwr}));
    do_frame(8'h95, 0);
    ri = 0;
    rx = '0;
    bs = '0;
    host.frame({10'h000, 16'h0000, 8'hd5, 7'h00, 8'h90, 15'h0000}, 54, 1'b0);
    check("overlap", exp_res(vin, 16, 1'b0) | exp_res(vin, 31, 1'b0), rx);
    check("overlap_busy", (65'(1) << 25) | (65'(1) << 40), bs);
    check("overlap_drv", 65'({1'b0, 2'b01, IN_X_PLUS, 1'b1, 1'b1, pen_touched}),
          65'(sn[44][7:0]));
    finish_test();
  end

  task automatic finish_test;
    $display("Checks %0d, errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
endmodule : touch_adc_serial_control_bench
